// file: serial_baud_rate_generator.sv
// bit-rate generator with its AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_rate_generator (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // write address channel
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   // write data channel
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // write response channel
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // read address channel
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   // read data channel
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // shift logic side
   input  wire logic        receive_idle_flag,
   output logic             base_tick,
   output logic             bit_tick
);
   import baud_pkg::*;

   // ---------------------------------------------------------------
   // register map: one 32-bit word each, unused bits read as zero
   // ---------------------------------------------------------------
   //   addr_baud_control   bit 0 wide_divider_select, read and write
   //                       bit 1 receive_idle_flag, read only
   //   addr_tx_status_ctl  bit 0 high_speed_select, read and write
   //                       bit 1 sync_mode, read and write
   //   addr_divisor_low    divisor bits 7:0, a write restarts the rate
   //   addr_divisor_high   divisor bits 15:8, a write restarts the rate
   //   addr_timer_count    live timer count in bits 15:0, read only
   // any other address answers SLVERR and changes nothing; a write
   // with wstrb[0] low answers OKAY and changes nothing
   // the high byte is kept in 8-bit mode but has no effect there,
   // so software may load it before setting the width select

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   rate_cfg_t   cfg;
   rate_cfg_t   next_cfg;
   logic [15:0] timer_count;
   logic        divisor_written;

   // ---------------------------------------------------------------
   // write channel state
   // ---------------------------------------------------------------
   logic        aw_full;
   logic        w_full;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_byte;
   logic        wr_lane0;
   logic        next_aw_full;
   logic        next_w_full;
   logic [7:0]  next_wr_addr;
   logic [7:0]  next_wr_byte;
   logic        next_wr_lane0;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        do_write;

   // ---------------------------------------------------------------
   // read channel state
   // ---------------------------------------------------------------
   rd_state_t   rd_state;
   rd_state_t   next_rd_state;
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic [31:0] rd_word;
   logic        rd_hit;

   // true for any address the slave answers with OKAY
   function automatic logic addr_known(input logic [7:0] a);
      logic k;
      k = 1'b0;
      if (a == addr_baud_control) begin
         k = 1'b1;
      end else if (a == addr_tx_status_ctl) begin
         k = 1'b1;
      end else if (a == addr_divisor_low) begin
         k = 1'b1;
      end else if (a == addr_divisor_high) begin
         k = 1'b1;
      end else if (a == addr_timer_count) begin
         k = 1'b1;
      end
      return k;
   endfunction

   // ---------------------------------------------------------------
   // write address and data capture, either order
   // ---------------------------------------------------------------
   // one write at a time: the pair is committed only when the
   // previous response has gone, so bvalid never overlaps two writes
   assign do_write = aw_full && w_full && !bvalid;

   always_comb begin
      next_aw_full  = aw_full;
      next_w_full   = w_full;
      next_wr_addr  = wr_addr;
      next_wr_byte  = wr_byte;
      next_wr_lane0 = wr_lane0;
      next_bvalid   = bvalid;
      next_bresp    = bresp;
      if (awvalid && awready) begin
         next_aw_full = 1'b1;
         next_wr_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_full   = 1'b1;
         next_wr_byte  = wdata[7:0];
         next_wr_lane0 = wstrb[0];
      end
      if (do_write) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = addr_known(wr_addr) ? resp_okay : resp_slverr;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      next_awready = !next_aw_full;
      next_wready  = !next_w_full;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_full  <= 1'b0;
         w_full   <= 1'b0;
         wr_addr  <= 8'h00;
         wr_byte  <= 8'h00;
         wr_lane0 <= 1'b0;
         awready  <= 1'b1;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= resp_okay;
      end else begin
         aw_full  <= next_aw_full;
         w_full   <= next_w_full;
         wr_addr  <= next_wr_addr;
         wr_byte  <= next_wr_byte;
         wr_lane0 <= next_wr_lane0;
         awready  <= next_awready;
         wready   <= next_wready;
         bvalid   <= next_bvalid;
         bresp    <= next_bresp;
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_comb begin
      next_cfg        = cfg;
      divisor_written = 1'b0;
      if (do_write && wr_lane0) begin
         if (wr_addr == addr_baud_control) begin
            next_cfg.wide_divider_select = wr_byte[bit_wide_divider];
         end else if (wr_addr == addr_tx_status_ctl) begin
            next_cfg.high_speed_select = wr_byte[bit_high_speed];
            next_cfg.sync_mode         = wr_byte[bit_sync_mode];
         end else if (wr_addr == addr_divisor_low) begin
            next_cfg.divisor[7:0] = wr_byte;
            divisor_written       = 1'b1;
         end else if (wr_addr == addr_divisor_high) begin
            next_cfg.divisor[15:8] = wr_byte;
            divisor_written        = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg.wide_divider_select <= reset_wide;
         cfg.high_speed_select   <= reset_high_speed;
         cfg.sync_mode           <= reset_sync_mode;
         cfg.divisor             <= {reset_divisor, reset_divisor};
      end else begin
         cfg <= next_cfg;
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always_comb begin
      next_rd_state = rd_state;
      next_arready  = arready;
      next_rvalid   = rvalid;
      next_rdata    = rdata;
      next_rresp    = rresp;
      case (rd_state)
         rd_idle: begin
            if (arvalid && arready) begin
               next_rd_state = rd_answer;
               next_arready  = 1'b0;
               next_rvalid   = 1'b1;
               next_rdata    = rd_word;
               next_rresp    = rd_hit ? resp_okay : resp_slverr;
            end
         end
         rd_answer: begin
            if (rready) begin
               next_rd_state = rd_idle;
               next_arready  = 1'b1;
               next_rvalid   = 1'b0;
            end
         end
         default: begin
            next_rd_state = rd_idle;
            next_arready  = 1'b1;
            next_rvalid   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_state <= rd_idle;
         arready  <= 1'b1;
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= resp_okay;
      end else begin
         rd_state <= next_rd_state;
         arready  <= next_arready;
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
      end
   end

   // ---------------------------------------------------------------
   // read word decode
   // ---------------------------------------------------------------
   // shares the address check with the write path, so both agree
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = addr_known(araddr);
      if (araddr == addr_baud_control) begin
         rd_word[bit_wide_divider] = cfg.wide_divider_select;
         rd_word[bit_rx_idle] = receive_idle_flag;
      end else if (araddr == addr_tx_status_ctl) begin
         rd_word[bit_high_speed] = cfg.high_speed_select;
         rd_word[bit_sync_mode]  = cfg.sync_mode;
      end else if (araddr == addr_divisor_low) begin
         rd_word[7:0] = cfg.divisor[7:0];
      end else if (araddr == addr_divisor_high) begin
         rd_word[7:0] = cfg.divisor[15:8];
      end else if (araddr == addr_timer_count) begin
         rd_word[15:0] = timer_count;
      end
   end

   // ---------------------------------------------------------------
   // rate chain: divisor timer then multiplier
   // ---------------------------------------------------------------
   // restart on divisor write
   // both stages restart so the first bit after a change is whole
   rate_timer u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .clear   (divisor_written),
      .cfg     (cfg),
      .count   (timer_count),
      .tick    (base_tick)
   );

   rate_prescaler u_prescaler (
      .clk       (clk),
      .reset_n   (reset_n),
      .clear     (divisor_written),
      .base_tick (base_tick),
      .cfg       (cfg),
      .bit_tick  (bit_tick)
   );

endmodule
`default_nettype wire

// file: baud_pkg.sv
// constants, types and helpers shared by the bit-rate generator
// ---------------------------------------------------------------
// Overview of operation
// - The bit-rate timer runs at either 8-bit or 16-bit width for async and sync use.
// - After reset the timer is 8 bits wide; wide_divider_select makes it 16 bits.
// - The divisor_high_byte and divisor_low_byte pair sets the timer period.
// - In async mode high_speed_select and wide_divider_select pick the multiplier.
// - In sync mode high_speed_select has no effect on the bit rate.
// - Async, 8-bit, normal speed gives clock / (64 * (divisor + 1)).
// - Any write to the divisor pair with wstrb[0] set clears the timer at once.
// ---------------------------------------------------------------
package baud_pkg;

   // register byte addresses
   localparam logic [7:0] addr_baud_control  = 8'h00;
   localparam logic [7:0] addr_tx_status_ctl = 8'h04;
   localparam logic [7:0] addr_divisor_low   = 8'h08;
   localparam logic [7:0] addr_divisor_high  = 8'h0C;
   localparam logic [7:0] addr_timer_count   = 8'h10;

   // field positions
   localparam int bit_wide_divider = 0;
   localparam int bit_rx_idle      = 1;
   localparam int bit_high_speed   = 0;
   localparam int bit_sync_mode    = 1;

   // reset values
   localparam logic       reset_wide       = 1'b0;
   localparam logic       reset_high_speed = 1'b0;
   localparam logic       reset_sync_mode  = 1'b0;
   localparam logic [7:0] reset_divisor    = 8'h00;

   // prescaler terminal counts (multiplier minus one)
   localparam logic [5:0] last_x64 = 6'h3F;
   localparam logic [5:0] last_x16 = 6'h0F;
   localparam logic [5:0] last_x4  = 6'h03;

   // bus answers
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // generator configuration as seen by the counters
   typedef struct packed {
      logic        wide_divider_select;
      logic        high_speed_select;
      logic        sync_mode;
      logic [15:0] divisor;
   } rate_cfg_t;

   typedef enum logic [0:0] {
      rd_idle,
      rd_answer
   } rd_state_t;

   // multiplier choice for the current mode
   function automatic logic [5:0] prescale_last(input rate_cfg_t c);
      logic [5:0] r;
      r = last_x4;
      if (c.sync_mode) begin
         r = last_x4;
      end else if (!c.wide_divider_select && !c.high_speed_select) begin
         r = last_x64;
      end else if (c.wide_divider_select && c.high_speed_select) begin
         r = last_x4;
      end else begin
         r = last_x16;
      end
      return r;
   endfunction

endpackage

// file: rate_timer.sv
// free-running divisor timer, 8 or 16 bits wide
`timescale 1ns/1ps
`default_nettype none
module rate_timer (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clear,
   input  wire baud_pkg::rate_cfg_t cfg,
   output logic [15:0]            count,
   output logic                   tick
);
   import baud_pkg::*;

   logic [15:0] limit;
   logic [15:0] next_count;
   logic        next_tick;

   // ---------------------------------------------------------------
   // reload and tick
   // ---------------------------------------------------------------
   always_comb begin
      // width select
      // narrow mode ignores the high byte entirely
      limit = cfg.wide_divider_select ? cfg.divisor :
              {8'h00, cfg.divisor[7:0]};
      next_count = count + 16'h0001;
      next_tick  = 1'b0;
      if (clear) begin
         next_count = 16'h0000;
      end else if (count >= limit) begin
         next_count = 16'h0000;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule
`default_nettype wire

// file: rate_prescaler.sv
// period multiplier after the divisor timer
`timescale 1ns/1ps
`default_nettype none
module rate_prescaler (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clear,
   input  wire logic              base_tick,
   input  wire baud_pkg::rate_cfg_t cfg,
   output logic                   bit_tick
);
   import baud_pkg::*;

   logic [5:0] phase;
   logic [5:0] last;
   logic [5:0] next_phase;
   logic       next_bit_tick;

   // ---------------------------------------------------------------
   // divide base ticks by the mode multiplier
   // ---------------------------------------------------------------
   always_comb begin
      last          = prescale_last(cfg);
      next_phase    = phase;
      next_bit_tick = 1'b0;
      if (clear) begin
         next_phase = 6'h00;
      end else if (base_tick) begin
         // >= keeps a mode change from stranding the phase
         if (phase >= last) begin
            next_phase    = 6'h00;
            next_bit_tick = 1'b1;
         end else begin
            next_phase = phase + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase    <= 6'h00;
         bit_tick <= 1'b0;
      end else begin
         phase    <= next_phase;
         bit_tick <= next_bit_tick;
      end
   end
endmodule
`default_nettype wire

// file: baud_assertions.sv
// concurrent checks on the bit-rate generator ports
`timescale 1ns/1ps
`default_nettype none
module baud_assertions
   import baud_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        base_tick,
   input wire logic        bit_tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // answers hold until the master takes them
   a_bresp_held:
      assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   a_rdata_held:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   // write commits two edges after a joint handshake
   a_write_answer:
      assert property (awvalid && awready && wvalid && wready && !bvalid
         |-> ##[2:3] bvalid)
      else $error("write answer late");
   a_read_next:
      assert property (arvalid && arready |=> rvalid)
      else $error("read answer not next cycle");
   a_ar_closed:
      assert property (rvalid |-> !arready)
      else $error("read address open while answer pending");
   a_rd_release:
      assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
   a_bit_after_base:
      assert property (bit_tick |-> $past(base_tick))
      else $error("bit tick without base tick");
   // smallest multiplier is four, so bit ticks never crowd
   a_bit_gap:
      assert property (bit_tick |=> !bit_tick [*3])
      else $error("bit ticks too close");

   cover property (bit_tick);
   cover property (bvalid && bresp == resp_slverr);
   cover property (rvalid && !rready);
endmodule
`default_nettype wire

// file: baud_shift_model.sv
// shift logic stand-in: busy for a frame of bit ticks
`timescale 1ns/1ps
`default_nettype none
module baud_shift_model #(
   parameter int frame_bits = 10
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic bit_tick,
   input  wire logic start,
   output logic      receive_idle_flag
);
   int left;
   // idle flag low while a frame is received
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) left <= 0;
      else if (start && left == 0) left <= frame_bits;
      else if (bit_tick && left != 0) left <= left - 1;
   end
   assign receive_idle_flag = (left == 0);
endmodule
`default_nettype wire

// file: tb_serial_baud_rate_generator.sv
// self-checking bench for the bit-rate generator
`timescale 1ns/1ps
`default_nettype none
module tb_serial_baud_rate_generator;
   import baud_pkg::*;
   logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, base_tick;
   logic        bit_tick, idle, start;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   int          err_total, checks, slow, cyc;

   serial_baud_rate_generator i_dut (.clk(clk), .reset_n(reset_n),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .receive_idle_flag(idle), .base_tick(base_tick), .bit_tick(bit_tick));
   baud_shift_model i_far (.clk(clk), .reset_n(reset_n),
      .bit_tick(bit_tick), .start(start), .receive_idle_flag(idle));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard, far above the expected few thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_n(input string n, input int e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", n, e, g);
      end
   endtask
   // bus master; slow delays the answer's acceptance
   task automatic wr(input logic [7:0] a, d, input logic [3:0] s);
      int lag;
      lag = slow;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      forever begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bready && bvalid === 1'b1) break;
         if (bvalid === 1'b1 && lag > 0) lag--;
         bready <= (lag == 0);
      end
      rsp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      int lag;
      lag = slow;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
      forever begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rready && rvalid === 1'b1) break;
         if (rvalid === 1'b1 && lag > 0) lag--;
         rready <= (lag == 0);
      end
      got = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // cycles from one tick to the next
   task automatic gap(input logic b, output int n);
      n = 0;
      do @(posedge clk); while ((b ? bit_tick : base_tick) !== 1'b1);
      do begin
         @(posedge clk);
         n++;
      end while ((b ? bit_tick : base_tick) !== 1'b1);
   endtask

   task automatic s_reset();
      int n;
      rd(addr_baud_control);
      chk("baud_control", 32'h2, got);
      rd(addr_tx_status_ctl);
      chk("tx_status", 32'h0, got);
      rd(addr_divisor_low);
      chk("div_low", 32'h0, got);
      rd(addr_divisor_high);
      chk("div_high", 32'h0, got);
      gap(1'b0, n);
      chk_n("base_period", 1, n);
      gap(1'b1, n);
      chk_n("bit_period", 64, n);
   endtask
   // rows: wide, high speed, sync
   task automatic s_modes();
      int n;
      int mult[6] = '{64, 16, 16, 4, 4, 4};
      logic [2:0] cfg[6] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h3};
      wr(addr_divisor_low, 8'h02, 4'h1);
      for (int i = 0; i < 6; i++) begin
         wr(addr_baud_control, {7'h0, cfg[i][2]}, 4'h1);
         wr(addr_tx_status_ctl, {6'h0, cfg[i][0], cfg[i][1]}, 4'h1);
         gap(1'b1, n);
         gap(1'b1, n);
         chk_n("bit_period", 3 * mult[i], n);
      end
   endtask
   task automatic s_wide();
      int n;
      wr(addr_divisor_high, 8'h01, 4'h1);
      wr(addr_divisor_low, 8'h02, 4'h1);
      wr(addr_baud_control, 8'h01, 4'h1);
      rd(addr_baud_control);
      chk("wide_set", 32'h3, got);
      gap(1'b0, n);
      chk_n("base_16bit", 259, n);
      wr(addr_baud_control, 8'h00, 4'h1);
      gap(1'b0, n);
      chk_n("base_8bit", 3, n);
   endtask
   // write lands mid-period; the count must start over
   task automatic s_restart();
      int n;
      wr(addr_divisor_low, 8'h09, 4'h1);
      for (int i = 0; i < 2; i++) begin
         do @(posedge clk); while (base_tick !== 1'b1);
         repeat (4) @(posedge clk);
         wr(i ? addr_divisor_high : addr_divisor_low, i ? 8'h0 : 8'h9, 4'h1);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (base_tick !== 1'b1);
         chk_n("restart", 9, n);
         rd(addr_timer_count);
         chk("timer_count", 32'h1, got);
      end
   endtask
   task automatic s_bus();
      slow = 3;
      wr(8'h14, 8'h55, 4'h1);
      chk("unmapped_wr", {30'h0, resp_slverr}, {30'h0, rsp});
      rd(8'h14);
      chk("unmapped_rd", {30'h0, resp_slverr}, {30'h0, rsp});
      wr(addr_divisor_low, 8'h33, 4'h0);
      chk("strobe_off_resp", {30'h0, resp_okay}, {30'h0, rsp});
      rd(addr_divisor_low);
      chk("strobe_off", 32'h9, got);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      rd(addr_baud_control);
      chk("rx_busy", 32'h0, got);
      do @(posedge clk); while (idle !== 1'b1);
      rd(addr_baud_control);
      chk("rx_idle", 32'h2, got);
      slow = 0;
   endtask

   initial begin
      {reset_n, awvalid, wvalid, bready, arvalid, rready, start} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      err_total = 0;
      checks = 0;
      slow = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      s_reset();
      s_modes();
      s_wide();
      s_restart();
      s_bus();
      close_out();
   end
endmodule

bind serial_baud_rate_generator baud_assertions i_chk (.clk(clk),
   .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .base_tick(base_tick),
   .bit_tick(bit_tick));
`default_nettype wire
